//--- src/fop_pkg.sv
// Package of constants and types for the buffer output port and flag logic
package fop_pkg;

	// ****************************************
	// Capacity and widths
	// ****************************************
	localparam int FOP_DEPTH_WORDS = 32768;   // Capacity in 20-bit words
	localparam int FOP_PTR_W = 17;            // Pointer and count width
	localparam int FOP_ADDR_W = 16;           // Memory address width
	localparam int FOP_DATA_W = 20;           // Full data width
	localparam int FOP_HALF_W = 10;           // Narrow data width
	localparam int FOP_OFS_W = 16;            // Width of one offset register
	localparam int FOP_SYNC_STAGES = 3;       // Pin synchroniser depth

	// ****************************************
	// Default offsets chosen by the two select pins
	// ****************************************
	localparam logic [FOP_OFS_W-1:0] FOP_OFS_DEF0 = 16'h007f;
	localparam logic [FOP_OFS_W-1:0] FOP_OFS_DEF1 = 16'h03ff;
	localparam logic [FOP_OFS_W-1:0] FOP_OFS_DEF2 = 16'h000f;
	localparam logic [FOP_OFS_W-1:0] FOP_OFS_DEF3 = 16'h001f;

	// ****************************************
	// Pipeline taps of the flags
	// ****************************************
	localparam int FOP_FULL_STAGES = 2;       // Full / input ready stages
	localparam int FOP_EMPTY_STD = 1;         // Index of stage 2 of empty pipe
	localparam int FOP_EMPTY_FALL_THROUGH_SELECT = 2;        // Index of stage 3 of empty pipe

	// Configuration captured at master reset
	typedef struct packed {
		logic fallThrough;
		logic inNarrow;
		logic outNarrow;
		logic [1:0] offsetSel;
	} fop_cfg_t;

	// Serial readback state
	typedef enum logic [0:0] {
		FOP_SER_IDLE = 1'b0,
		FOP_SER_SHIFT = 1'b1
	} fop_ser_t;

endpackage : fop_pkg

//--- src/fop_sync.sv
// Three-stage pin synchroniser with an agreement filter
`timescale 1ns/1ns
`default_nettype none
module fop_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Pin side
	input wire logic [WIDTH-1:0] pinIn,
	// Core side
	output logic [WIDTH-1:0] levelOut
);
	import fop_pkg::*;

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] level_r;

	// Stages one to three; only stage two reads stage one
	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			meta_r <= pinIn;
			s2_r <= meta_r;
			s3_r <= s2_r;
		end
	end

	// A bit changes only once stages two and three agree
	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			always_ff @(posedge core_clk) begin
				if (reset) begin
					level_r[b] <= 1'b0;
				end else if (s2_r[b] == s3_r[b]) begin
					level_r[b] <= s3_r[b];
				end
			end
		end
	endgenerate

	assign levelOut = level_r;

endmodule : fop_sync
`default_nettype wire

//--- src/fop_mem.sv
// Simple dual-port storage array with registered read data
`timescale 1ns/1ns
`default_nettype none
module fop_mem #(
	parameter int ADDR_W = fop_pkg::FOP_ADDR_W,
	parameter int DATA_W = fop_pkg::FOP_DATA_W
) (
	// Clock
	input wire logic core_clk,
	// Write port
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	// Read port
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);
	import fop_pkg::*;

	logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rdData_r;

	// Write and registered read
	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
		rdData_r <= store[rdAddr];
	end

	assign rdData = rdData_r;

endmodule : fop_mem
`default_nettype wire

//--- src/fop_port.sv
// Buffer read port, output enable control and status flags
// Operation
// - Offsets shift out on serial output, one bit per serial clock rise, while readback enabled.
// - Output enable low drives data from output register; high puts data bus high-Z.
// - During master or partial reset only output enable controls high-Z; read select ignored.
// - Read select change takes effect on data drive at next read clock rise.
// - With output enable low, outputs driven after reset until first read clock rise.
// - Flags ignore read select; empty flag rises after first write regardless.
// - Fall-through first word loads output register even while read select is high.
// - With write select high, write data inputs are ignored; writes need select low.
// - Width selects sampled at master reset; flags count on chosen boundary.
// - Two select pins choose one of four default offsets at master reset.
// - Twenty output lines carry data in wide mode, lower ten in narrow mode.
// - Standard full flag low at capacity D, inhibiting writes; D doubles when both narrow.
// - Fall-through input ready goes high after D+1 writes, counting output register word.
// - Full / input ready updates on write clock rises through two register stages.
// - In retransmit mode full and almost-full compare write pointer with marked location.
// - Standard empty flag low when no words remain, inhibiting reads; high otherwise.
// - Output ready falls when first word becomes valid, stays low through last shift.
// - Output ready rises only on a true read with no further word, or on a retransmit; data holds.
// - Empty / output ready update on read clock: two stages standard, three fall-through.
// - Standard almost-full low once D minus m words written without reads.
// - Fall-through almost-full low after D+1 minus m writes, counting output word.
// - Fall-through select sampled at master reset chooses ready flags or empty/full.
// - Each readback start begins at the first offset bit, not where it stopped.
`timescale 1ns/1ns
`default_nettype none
module fop_port #(
	parameter int DEPTH_WORDS = fop_pkg::FOP_DEPTH_WORDS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Pin clocks
	input wire logic write_clk,
	input wire logic read_clk,
	input wire logic serial_clk,
	// Reset and strap pins
	input wire logic master_reset_n,
	input wire logic partial_reset_n,
	input wire logic fall_through_select,
	input wire logic input_width_select,
	input wire logic output_width_select,
	input wire logic default_offset_select_0,
	input wire logic default_offset_select_1,
	// Write port
	input wire logic write_enable_n,
	input wire logic write_port_select_n,
	input wire logic [fop_pkg::FOP_DATA_W-1:0] write_data_in,
	// Read port
	input wire logic read_enable_n,
	input wire logic read_port_select_n,
	input wire logic output_enable_n,
	input wire logic mark_n,
	input wire logic retransmit_n,
	output logic [fop_pkg::FOP_DATA_W-1:0] read_data_out,
	output logic read_data_oe_n,
	// Serial offset port
	input wire logic offset_load_enable_n,
	input wire logic offset_read_enable_n,
	input wire logic serial_in,
	output logic serial_out,
	// Flags
	output logic full_flag_n,
	output logic empty_flag_n,
	output logic almost_full_flag_n
);
	import fop_pkg::*;

	localparam logic [FOP_PTR_W-1:0] CAP_WIDE = FOP_PTR_W'(DEPTH_WORDS);
	localparam logic [FOP_PTR_W-1:0] ONE = 17'h00001;
	localparam logic [FOP_PTR_W-1:0] ZERO = 17'h00000;
	localparam int SER_W = 2 * FOP_OFS_W;
	localparam logic [4:0] SER_LAST = 5'(SER_W - 1);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] clkLvl;
	logic [6:0] strapLvl;
	logic [FOP_DATA_W+1:0] wrLvl;
	logic [4:0] rdLvl;
	logic [2:0] serLvl;

	fop_sync #(.WIDTH(3)) u_clkSync (
		.core_clk(core_clk), .reset(reset),
		.pinIn({write_clk, read_clk, serial_clk}), .levelOut(clkLvl));
	fop_sync #(.WIDTH(7)) u_strapSync (
		.core_clk(core_clk), .reset(reset),
		.pinIn({master_reset_n, partial_reset_n, fall_through_select, input_width_select,
			output_width_select, default_offset_select_1, default_offset_select_0}),
		.levelOut(strapLvl));
	fop_sync #(.WIDTH(FOP_DATA_W + 2)) u_wrSync (
		.core_clk(core_clk), .reset(reset),
		.pinIn({write_enable_n, write_port_select_n, write_data_in}), .levelOut(wrLvl));
	fop_sync #(.WIDTH(5)) u_rdSync (
		.core_clk(core_clk), .reset(reset),
		.pinIn({read_enable_n, read_port_select_n, output_enable_n, mark_n, retransmit_n}),
		.levelOut(rdLvl));
	fop_sync #(.WIDTH(3)) u_serSync (
		.core_clk(core_clk), .reset(reset),
		.pinIn({offset_load_enable_n, offset_read_enable_n, serial_in}), .levelOut(serLvl));

	// Named views of the synchronised levels
	wire mrsN = strapLvl[6];
	wire prsN = strapLvl[5];
	wire wenN = wrLvl[FOP_DATA_W+1];
	wire wcsN = wrLvl[FOP_DATA_W];
	wire [FOP_DATA_W-1:0] wrData = wrLvl[FOP_DATA_W-1:0];
	wire renN = rdLvl[4];
	wire rcsN = rdLvl[3];
	wire oeN = rdLvl[2];
	wire markN = rdLvl[1];
	wire rtN = rdLvl[0];
	wire senN = serLvl[2];
	wire srenN = serLvl[1];
	wire serIn = serLvl[0];

	// ****************************************
	// Clock edge detection
	// ****************************************
	logic [2:0] clkPrev_r;
	always_ff @(posedge core_clk) begin
		clkPrev_r <= reset ? 3'h0 : clkLvl;
	end
	wire wclkRise = clkLvl[2] & ~clkPrev_r[2];
	wire rclkRise = clkLvl[1] & ~clkPrev_r[1];
	wire sclkRise = clkLvl[0] & ~clkPrev_r[0];
	wire inReset = ~mrsN | ~prsN;

	// ****************************************
	// Configuration captured at master reset
	// ****************************************
	fop_cfg_t cfg_r;
	logic [FOP_OFS_W-1:0] defOfs;
	always_comb begin
		case (strapLvl[1:0])
			2'h0: defOfs = FOP_OFS_DEF0;
			2'h1: defOfs = FOP_OFS_DEF1;
			2'h2: defOfs = FOP_OFS_DEF2;
			2'h3: defOfs = FOP_OFS_DEF3;
			default: defOfs = FOP_OFS_DEF0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg_r <= '0;
		end else if (~mrsN) begin
			cfg_r <= '{fallThrough: strapLvl[4], inNarrow: strapLvl[3],
				outNarrow: strapLvl[2], offsetSel: strapLvl[1:0]};
		end
	end

	// ****************************************
	// Pointers, counts and capacity
	// ****************************************
	logic [FOP_PTR_W-1:0] wrPtr_r;
	logic [FOP_PTR_W-1:0] rdPtr_r;
	logic [FOP_PTR_W-1:0] markPtr_r;
	logic markMode_r;
	logic outValid_r;
	logic [FOP_DATA_W-1:0] outReg_r;
	logic [FOP_DATA_W-1:0] memRdData;

	wire bothNarrow = cfg_r.inNarrow & cfg_r.outNarrow;
	wire [FOP_PTR_W-1:0] capWords = bothNarrow ? (CAP_WIDE << 1) : CAP_WIDE;
	wire [FOP_PTR_W-1:0] memCount = wrPtr_r - rdPtr_r;
	wire [FOP_PTR_W-1:0] basePtr = markMode_r ? markPtr_r : rdPtr_r;
	wire [FOP_PTR_W-1:0] outWord = (cfg_r.fallThrough & outValid_r) ? ONE : ZERO;
	wire [FOP_PTR_W-1:0] fullCount = (wrPtr_r - basePtr) + outWord;
	wire [FOP_PTR_W-1:0] fullLimit = capWords + (cfg_r.fallThrough ? ONE : ZERO);
	wire memFull = (wrPtr_r - basePtr) >= capWords;
	wire memHasWord = memCount != ZERO;

	// Offsets, full offset in the upper half of the shift chain
	logic [SER_W-1:0] offsets_r;
	wire [FOP_PTR_W-1:0] fullOfs = {1'b0, offsets_r[SER_W-1:FOP_OFS_W]};
	wire [FOP_PTR_W-1:0] almostLimit = fullLimit - fullOfs;
	wire fullNow = fullCount >= fullLimit;
	wire almostNow = fullCount >= almostLimit;

	// ****************************************
	// Write path
	// ****************************************
	wire writeOk = wclkRise & ~wenN & ~wcsN & ~memFull & ~inReset;
	wire [FOP_DATA_W-1:0] wrWord = cfg_r.inNarrow ?
		{{(FOP_DATA_W-FOP_HALF_W){1'b0}}, wrData[FOP_HALF_W-1:0]} : wrData;

	fop_mem u_mem (
		.core_clk(core_clk),
		.wrEn(writeOk),
		.wrAddr(wrPtr_r[FOP_ADDR_W-1:0]),
		.wrData(wrWord),
		.rdAddr(rdPtr_r[FOP_ADDR_W-1:0]),
		.rdData(memRdData)
	);

	always_ff @(posedge core_clk) begin
		if (reset | inReset) begin
			wrPtr_r <= ZERO;
		end else if (writeOk) begin
			wrPtr_r <= wrPtr_r + ONE;
		end
	end

	// Full and almost-full, two stages on write clock rises
	logic [FOP_FULL_STAGES-1:0] fullPipe_r;
	logic [FOP_FULL_STAGES-1:0] almostPipe_r;
	always_ff @(posedge core_clk) begin
		if (reset | inReset) begin
			fullPipe_r <= '0;
			almostPipe_r <= '0;
		end else if (wclkRise) begin
			fullPipe_r <= {fullPipe_r[0], fullNow};
			almostPipe_r <= {almostPipe_r[0], almostNow};
		end
	end
	assign full_flag_n = cfg_r.fallThrough ? fullPipe_r[1] : ~fullPipe_r[1];
	assign almost_full_flag_n = ~almostPipe_r[1];

	// ****************************************
	// Read path and empty / output ready
	// ****************************************
	logic [2:0] emptyPipe_r;
	always_ff @(posedge core_clk) begin
		if (reset | inReset) begin
			emptyPipe_r <= 3'h0;
		end else if (rclkRise) begin
			emptyPipe_r <= {emptyPipe_r[1:0], memHasWord};
		end
	end

	wire trueRead = rclkRise & ~renN & ~rcsN;
	wire wordSeen = cfg_r.fallThrough ? emptyPipe_r[FOP_EMPTY_STD] : emptyPipe_r[0];
	wire stdRead = ~cfg_r.fallThrough & trueRead & emptyPipe_r[0] & memHasWord;
	wire ftNeed = ~outValid_r | trueRead;
	wire ftLoad = cfg_r.fallThrough & rclkRise & ftNeed & wordSeen & memHasWord;
	wire ftDrain = cfg_r.fallThrough & trueRead & outValid_r & ~ftLoad;
	wire doRetx = rclkRise & ~rtN & ~rcsN & markMode_r;
	wire popWord = (stdRead | ftLoad) & ~inReset;

	always_ff @(posedge core_clk) begin
		if (reset | inReset) begin
			rdPtr_r <= ZERO;
			outValid_r <= 1'b0;
		end else if (doRetx) begin
			rdPtr_r <= markPtr_r;
			outValid_r <= 1'b0;
		end else begin
			if (popWord) begin
				rdPtr_r <= rdPtr_r + ONE;
			end
			if (ftLoad) begin
				outValid_r <= 1'b1;
			end else if (ftDrain) begin
				outValid_r <= 1'b0;
			end
		end
	end

	// Output register; core or master reset clears it, data holds after the last read
	always_ff @(posedge core_clk) begin
		if (reset | ~mrsN) begin
			outReg_r <= '0;
		end else if (popWord) begin
			outReg_r <= memRdData;
		end
	end

	// Mark location for retransmit mode
	always_ff @(posedge core_clk) begin
		if (reset | inReset) begin
			markPtr_r <= ZERO;
			markMode_r <= 1'b0;
		end else if (rclkRise) begin
			markMode_r <= ~markN;
			if (~markN & ~markMode_r) begin
				markPtr_r <= rdPtr_r;
			end
		end
	end

	// Standard empty uses stage 2, output ready is the inverted output valid bit
	assign empty_flag_n = cfg_r.fallThrough ? ~outValid_r : emptyPipe_r[FOP_EMPTY_STD];

	// ****************************************
	// Output drive control
	// ****************************************
	logic rcsDrive_r;
	always_ff @(posedge core_clk) begin
		if (reset | inReset) begin
			rcsDrive_r <= 1'b1;
		end else if (rclkRise) begin
			rcsDrive_r <= ~rcsN;
		end
	end
	wire driveOn = ~oeN & (inReset | rcsDrive_r);
	assign read_data_oe_n = ~driveOn;
	assign read_data_out = cfg_r.outNarrow ?
		{{(FOP_DATA_W-FOP_HALF_W){1'b0}}, outReg_r[FOP_HALF_W-1:0]} : outReg_r;

	// ****************************************
	// Serial offset load and readback
	// ****************************************
	fop_ser_t serState_r;
	logic [4:0] serIdx_r;
	logic serOut_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			offsets_r <= {FOP_OFS_DEF0, FOP_OFS_DEF0};
		end else if (~mrsN) begin
			offsets_r <= {defOfs, defOfs};
		end else if (sclkRise & ~senN) begin
			offsets_r <= {offsets_r[SER_W-2:0], serIn};
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset | srenN) begin
			serState_r <= FOP_SER_IDLE;
			serIdx_r <= 5'h00;
			serOut_r <= 1'b0;
		end else begin
			case (serState_r)
				FOP_SER_IDLE: begin
					serState_r <= FOP_SER_SHIFT;
					serIdx_r <= 5'h00;
				end
				FOP_SER_SHIFT: begin
					if (sclkRise) begin
						serOut_r <= offsets_r[SER_LAST - serIdx_r];
						serIdx_r <= (serIdx_r == SER_LAST) ? 5'h00 : serIdx_r + 5'h01;
					end
				end
				default: serState_r <= FOP_SER_IDLE;
			endcase
		end
	end
	assign serial_out = serOut_r;

	// ****************************************
	// Checks
	// ****************************************
	hiz_in_reset_a: assert property (@(posedge core_clk) disable iff (reset)
		inReset |-> (read_data_oe_n == oeN))
		else $error("data drive not set by output enable alone in reset");
	rcs_follow_a: assert property (@(posedge core_clk) disable iff (reset)
		(rclkRise && !inReset) |=> (rcsDrive_r == !$past(rcsN)))
		else $error("read select not taken at read clock rise");
	oe_high_hiz_a: assert property (@(posedge core_clk) disable iff (reset)
		oeN |-> read_data_oe_n)
		else $error("data driven with output enable high");
	no_write_full_a: assert property (@(posedge core_clk) disable iff (reset)
		(memFull && !inReset) |=> (wrPtr_r == $past(wrPtr_r)))
		else $error("write accepted while full");
	no_write_unsel_a: assert property (@(posedge core_clk) disable iff (reset)
		(wcsN && !inReset) |=> (wrPtr_r == $past(wrPtr_r)))
		else $error("write accepted with write select high");
	full_two_stage_a: assert property (@(posedge core_clk) disable iff (reset || inReset)
		(wclkRise && !inReset)
		|=> (fullPipe_r == {$past(fullPipe_r[0]), $past(fullNow)}))
		else $error("full flag not after two write clock stages");
	empty_no_read_a: assert property (@(posedge core_clk) disable iff (reset)
		(!cfg_r.fallThrough && !memHasWord && !inReset && !doRetx)
		|=> (rdPtr_r == $past(rdPtr_r)))
		else $error("read from empty buffer");
	ready_rise_a: assert property (@(posedge core_clk) disable iff (reset || inReset)
		(cfg_r.fallThrough && $rose(empty_flag_n)) |-> $past(trueRead))
		else $error("output ready rose without a true read");
	narrow_out_a: assert property (@(posedge core_clk) disable iff (reset)
		cfg_r.outNarrow |-> (read_data_out[FOP_DATA_W-1:FOP_HALF_W] == '0))
		else $error("upper lines active in narrow mode");
	ser_restart_a: assert property (@(posedge core_clk) disable iff (reset)
		$rose(!srenN) |=> (serIdx_r == 5'h00))
		else $error("readback did not restart at first bit");

endmodule : fop_port
`default_nettype wire

//--- sim/fop_far_end.sv
// Writer and reader logic that faces the buffer pins, on stop-start clocks
`timescale 1ns/1ns
`default_nettype none
module fop_far_end (
	// Core clock used only for pacing
	input wire logic core_clk,
	// Pin clocks
	output logic write_clk,
	output logic read_clk,
	output logic serial_clk,
	// Write side
	output logic write_enable_n,
	output logic write_port_select_n,
	output logic [fop_pkg::FOP_DATA_W-1:0] write_data_in,
	// Read side
	output logic read_enable_n,
	output logic read_port_select_n
);
	import fop_pkg::*;

	// ****************************************
	// Idle levels
	// ****************************************
	initial begin
		{write_clk, read_clk, serial_clk} = 3'h0;
		{write_enable_n, write_port_select_n, read_enable_n, read_port_select_n} = 4'hf;
		write_data_in = 20'h00000;
	end

	// One 40 ns pulse in an 80 ns slot, offset from the core clock; clocks stand still between pulses
	task automatic clk_pulse(input int which);
		#3;
		if (which == 0) write_clk = 1'b1;
		else if (which == 1) read_clk = 1'b1;
		else serial_clk = 1'b1;
		#40;
		{write_clk, read_clk, serial_clk} = 3'h0;
		#37;
	endtask : clk_pulse

	// Let the synchronisers and flag pipes settle
	task automatic settle();
		repeat (6) @(negedge core_clk);
	endtask : settle

	// One write; data is inverted once released so stale values never match
	task automatic wr(input logic [FOP_DATA_W-1:0] d, input logic sel_n);
		write_data_in = d;
		write_enable_n = 1'b0;
		write_port_select_n = sel_n;
		clk_pulse(0);
		write_enable_n = 1'b1;
		write_port_select_n = 1'b1;
		write_data_in = ~d;
		settle();
	endtask : wr

	// Write clock with no write
	task automatic widle();
		clk_pulse(0);
		settle();
	endtask : widle

	// Read clock; select is a level the reader keeps after the edge
	task automatic rpulse(input logic ren_n, input logic rcs_n);
		read_enable_n = ren_n;
		read_port_select_n = rcs_n;
		clk_pulse(1);
		read_enable_n = 1'b1;
		settle();
	endtask : rpulse

	// Serial clock for offset readback
	task automatic spulse();
		clk_pulse(2);
		settle();
	endtask : spulse

endmodule : fop_far_end
`default_nettype wire

//--- sim/fifo_output_port_and_flags_tb.sv
// Self-checking bench of the buffer output port and flag logic
`timescale 1ns/1ns
`default_nettype none
module fifo_output_port_and_flags_tb;
	import fop_pkg::*;

	// ****************************************
	// Signals and counters
	// ****************************************
	localparam int DEPTH = 20;
	localparam int AF_AT = DEPTH - int'(FOP_OFS_DEF2);
	localparam int LIMIT = 20000;
	localparam logic [31:0] CHAIN = {FOP_OFS_DEF2, FOP_OFS_DEF2};
	logic core_clk, reset, master_reset_n, partial_reset_n, fall_through_select;
	logic input_width_select, output_width_select, default_offset_select_0;
	logic default_offset_select_1, output_enable_n, offset_read_enable_n;
	logic write_clk, read_clk, serial_clk, write_enable_n, write_port_select_n;
	logic read_enable_n, read_port_select_n, read_data_oe_n, serial_out;
	logic full_flag_n, empty_flag_n, almost_full_flag_n;
	logic mark_n, retransmit_n;
	logic [FOP_DATA_W-1:0] write_data_in, read_data_out;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;

	fop_far_end far (.core_clk(core_clk), .write_clk(write_clk), .read_clk(read_clk),
		.serial_clk(serial_clk), .write_enable_n(write_enable_n),
		.write_port_select_n(write_port_select_n), .write_data_in(write_data_in),
		.read_enable_n(read_enable_n), .read_port_select_n(read_port_select_n));

	fop_port #(.DEPTH_WORDS(DEPTH)) dut (.core_clk(core_clk), .reset(reset),
		.write_clk(write_clk), .read_clk(read_clk), .serial_clk(serial_clk),
		.master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
		.fall_through_select(fall_through_select), .input_width_select(input_width_select),
		.output_width_select(output_width_select),
		.default_offset_select_0(default_offset_select_0),
		.default_offset_select_1(default_offset_select_1), .write_enable_n(write_enable_n),
		.write_port_select_n(write_port_select_n), .write_data_in(write_data_in),
		.read_enable_n(read_enable_n), .read_port_select_n(read_port_select_n),
		.output_enable_n(output_enable_n), .mark_n(mark_n), .retransmit_n(retransmit_n),
		.read_data_out(read_data_out), .read_data_oe_n(read_data_oe_n),
		.offset_load_enable_n(1'b1), .offset_read_enable_n(offset_read_enable_n),
		.serial_in(1'b0), .serial_out(serial_out), .full_flag_n(full_flag_n),
		.empty_flag_n(empty_flag_n), .almost_full_flag_n(almost_full_flag_n));

	// ****************************************
	// Clock, timeout and verdict
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// A hang counts as a mismatch
	always @(posedge core_clk) begin
		cycles++;
		if (cycles >= LIMIT) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [FOP_DATA_W-1:0] seen, input logic [FOP_DATA_W-1:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic chkb(input logic seen, input logic exp);
		chk({19'h0, seen}, {19'h0, exp});
	endtask : chkb

	function automatic logic [FOP_DATA_W-1:0] wordOf(input int i);
		return 20'h5a000 ^ 20'(i);
	endfunction : wordOf

	// ****************************************
	// Sequences
	// ****************************************
	// Master reset with straps; read select held high to show it has no say
	task automatic mrst(input logic ft, input logic nar, input logic [1:0] sel);
		fall_through_select = ft;
		{input_width_select, output_width_select} = {nar, nar};
		{default_offset_select_1, default_offset_select_0} = sel;
		far.read_port_select_n = 1'b1;
		master_reset_n = 1'b0;
		repeat (10) @(negedge core_clk);
		chkb(read_data_oe_n, 1'b0);
		master_reset_n = 1'b1;
		repeat (8) @(negedge core_clk);
	endtask : mrst

	// Serial readback always restarts at the first chain bit
	task automatic sread(input int n);
		offset_read_enable_n = 1'b0;
		repeat (6) @(negedge core_clk);
		for (int k = 0; k < n; k++) begin
			far.spulse();
			chkb(serial_out, CHAIN[31-k]);
		end
		offset_read_enable_n = 1'b1;
		repeat (6) @(negedge core_clk);
	endtask : sread

	// Writes without reads, watching the flags around both thresholds
	task automatic fill(input int n, input int afAt, input int fullAt, input logic ft);
		for (int i = 1; i <= n; i++) begin
			far.wr(wordOf(i), 1'b0);
			if (ft && i == 1) repeat (3) far.rpulse(1'b1, 1'b1);
			if (i == afAt - 1 || i == afAt || i == fullAt - 1 || i == fullAt) begin
				repeat (2) far.widle();
				chkb(almost_full_flag_n, logic'(i < afAt));
				chkb(full_flag_n, ft ? logic'(i >= fullAt) : logic'(i < fullAt));
			end
		end
	endtask : fill

	initial begin
		{reset, master_reset_n, partial_reset_n, offset_read_enable_n} = 4'hf;
		{mark_n, retransmit_n} = 2'h3;
		{fall_through_select, input_width_select, output_width_select} = 3'h0;
		{default_offset_select_0, default_offset_select_1, output_enable_n} = 3'h0;
		repeat (12) @(negedge core_clk);
		reset = 1'b0;
		mrst(1'b0, 1'b0, 2'h2);
		chkb(empty_flag_n, 1'b0);
		chkb(full_flag_n, 1'b1);
		// Output drive: held until the first read clock, then follows select
		chkb(read_data_oe_n, 1'b0);
		far.rpulse(1'b1, 1'b1);
		chkb(read_data_oe_n, 1'b1);
		far.rpulse(1'b1, 1'b0);
		chkb(read_data_oe_n, 1'b0);
		output_enable_n = 1'b1;
		repeat (6) @(negedge core_clk);
		chkb(read_data_oe_n, 1'b1);
		output_enable_n = 1'b0;
		sread(14);
		sread(13);
		// Write with the port deselected is dropped
		far.wr(wordOf(99), 1'b1);
		repeat (3) far.rpulse(1'b1, 1'b0);
		chkb(empty_flag_n, 1'b0);
		fill(DEPTH, AF_AT, DEPTH, 1'b0);
		far.wr(wordOf(DEPTH + 1), 1'b0);
		// Empty flag needs two read clocks before the first read is taken
		repeat (2) far.rpulse(1'b1, 1'b0);
		chkb(empty_flag_n, 1'b1);
		for (int i = 1; i <= DEPTH; i++) begin
			far.rpulse(1'b0, 1'b0);
			chk(read_data_out, wordOf(i));
		end
		repeat (2) far.rpulse(1'b1, 1'b0);
		chkb(empty_flag_n, 1'b0);
		far.rpulse(1'b0, 1'b0);
		chk(read_data_out, wordOf(DEPTH));
		// Retransmit mode: flags count from the mark, replay with select low
		mark_n = 1'b0;
		far.rpulse(1'b1, 1'b0);
		for (int i = 1; i <= AF_AT; i++) far.wr(wordOf(50 + i), 1'b0);
		repeat (2) far.rpulse(1'b1, 1'b0);
		repeat (AF_AT) far.rpulse(1'b0, 1'b0);
		repeat (2) far.widle();
		chkb(almost_full_flag_n, 1'b0);
		chk(read_data_out, wordOf(50 + AF_AT));
		retransmit_n = 1'b0;
		far.rpulse(1'b1, 1'b0);
		retransmit_n = 1'b1;
		repeat (2) far.rpulse(1'b1, 1'b0);
		far.rpulse(1'b0, 1'b0);
		chk(read_data_out, wordOf(51));
		mark_n = 1'b1;
		// Narrow ports: empty flag two read clocks behind, select ignored
		mrst(1'b0, 1'b1, 2'h2);
		far.wr(20'habcde, 1'b0);
		far.rpulse(1'b1, 1'b1);
		chkb(empty_flag_n, 1'b0);
		far.rpulse(1'b1, 1'b1);
		chkb(empty_flag_n, 1'b1);
		far.rpulse(1'b0, 1'b0);
		chk(read_data_out, 20'h000de);
		// Partial reset: output enable alone decides the drive
		partial_reset_n = 1'b0;
		far.read_port_select_n = 1'b1;
		repeat (8) @(negedge core_clk);
		chkb(read_data_oe_n, 1'b0);
		output_enable_n = 1'b1;
		repeat (6) @(negedge core_clk);
		chkb(read_data_oe_n, 1'b1);
		output_enable_n = 1'b0;
		partial_reset_n = 1'b1;
		repeat (8) @(negedge core_clk);
		// Fall-through: first word lands while deselected, three read clocks late
		mrst(1'b1, 1'b0, 2'h2);
		chkb(full_flag_n, 1'b0);
		chkb(empty_flag_n, 1'b1);
		far.wr(wordOf(40), 1'b0);
		repeat (2) far.rpulse(1'b1, 1'b1);
		chkb(empty_flag_n, 1'b1);
		far.rpulse(1'b1, 1'b1);
		chkb(empty_flag_n, 1'b0);
		chk(read_data_out, wordOf(40));
		chkb(read_data_oe_n, 1'b1);
		far.rpulse(1'b1, 1'b0);
		chkb(read_data_oe_n, 1'b0);
		far.rpulse(1'b0, 1'b0);
		chkb(empty_flag_n, 1'b1);
		chk(read_data_out, wordOf(40));
		fill(DEPTH + 1, DEPTH + 1 - int'(FOP_OFS_DEF2), DEPTH + 1, 1'b1);
		print_verdict();
	end

endmodule : fifo_output_port_and_flags_tb
`default_nettype wire
